/* File: hw/fcio_consts.vh */
// fcio_consts.vh: constants of the flash command and identification host
// assumes: included by bare name by the host design files
`ifndef FCIO_CONSTS_VH
`define FCIO_CONSTS_VH
// host register offsets (byte addresses, one aligned word each)
`define FCIO_REG_CTRL      8'h00
`define FCIO_REG_ADDR      8'h04
`define FCIO_REG_WDATA     8'h08
`define FCIO_REG_STATUS    8'h0C
`define FCIO_REG_RDATA     8'h10
`define FCIO_REG_ID0       8'h14
`define FCIO_REG_ID1       8'h18
`define FCIO_REG_ID2       8'h1C
`define FCIO_REG_ID3       8'h20
// control fields
`define FCIO_CTRL_GO       0
`define FCIO_CTRL_OP_LSB   4
`define FCIO_CTRL_OP_MSB   7
// operations
`define FCIO_OP_READ       4'h0
`define FCIO_OP_WRITE      4'h1
`define FCIO_OP_ID_READ    4'h2
`define FCIO_OP_RESET      4'h3
`define FCIO_OP_ABORT_RST  4'h4
`define FCIO_OP_EXIT       4'h5
`define FCIO_OP_PWD_PROG   4'h6
// status fields
`define FCIO_ST_BUSY       0
`define FCIO_ST_DONE       1
`define FCIO_ST_ERR        2
`define FCIO_ST_TIMEX      3
// identification overlay word offsets
`define FCIO_ID_MAKER      4'h0
`define FCIO_ID_PART       4'h1
`define FCIO_ID_LOCK       4'h2
`define FCIO_ID_FEATURE    4'h3
// command words and unlock addresses
`define FCIO_UNLOCK_A1     16'h0555
`define FCIO_UNLOCK_A2     16'h02AA
`define FCIO_UNLOCK_D1     16'h00AA
`define FCIO_UNLOCK_D2     16'h0055
`define FCIO_CMD_ID_ENTRY  16'h0090
`define FCIO_CMD_RESET     16'h00F0
`define FCIO_CMD_PROGRAM   16'h00A0
`define FCIO_CMD_EXIT2     16'h0000
`define FCIO_SECTOR_LSB    16
`define FCIO_PWD_LAST      2'h3
// bus timing: cycle of 100 ns, random access time 100 ns, minimum
`define FCIO_CLK_NS        100
`define FCIO_RANDOM_ACCESS_TIME_NS       100
`define FCIO_RANDOM_ACCESS_TIME_CYC      ((`FCIO_RANDOM_ACCESS_TIME_NS + `FCIO_CLK_NS - 1) / `FCIO_CLK_NS)
`define FCIO_PULSE_CYC     2
`define FCIO_SYNC_CYC      3
`define FCIO_EXCEED_BIT    5
`endif

/* File: hw/fcio_bus_cycle.v */
// fcio_bus_cycle.v: one asynchronous flash bus cycle, read or write
// assumes: flash data bus is split into input, output and enable signals
`timescale 1ns/1ns
`include "fcio_consts.vh"
module fcio_bus_cycle (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // request
  input  wire        start,
  input  wire        is_read,
  input  wire [25:0] addr,
  input  wire [15:0] wdata,
  output reg         done_ff,
  output reg  [15:0] rdata_ff,
  // flash pins
  output reg         ce_n_ff,
  output reg         oe_n_ff,
  output reg         we_n_ff,
  output reg  [25:0] fa_ff,
  output reg  [15:0] dq_o_ff,
  output reg         dq_oe_ff,
  input  wire [15:0] dq_i
);
  localparam S_IDLE = 3'b001;
  localparam S_ACT  = 3'b010;
  localparam S_END  = 3'b100;
  // read strobe covers access time plus the three sync stages
  localparam integer RD_CNT_I = `FCIO_RANDOM_ACCESS_TIME_CYC + `FCIO_SYNC_CYC;
  localparam integer WR_CNT_I = `FCIO_PULSE_CYC;
  localparam [3:0]   RD_CNT   = RD_CNT_I[3:0];
  localparam [3:0]   WR_CNT   = WR_CNT_I[3:0];
  reg [2:0]  st_ff;
  reg [3:0]  cnt_ff;
  reg        rd_ff;
  reg [15:0] s1_ff;
  reg [15:0] s2_ff;
  reg [15:0] s3_ff;
  always @(posedge aclk) begin
    s1_ff <= dq_i;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff    <= S_IDLE;
      cnt_ff   <= 4'h0;
      rd_ff    <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= 16'h0000;
      ce_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      fa_ff    <= 26'h000_0000;
      dq_o_ff  <= 16'h0000;
      dq_oe_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (start) begin
            // fresh cycle: chip enable always falls from high
            rd_ff    <= is_read;
            fa_ff    <= addr;
            dq_o_ff  <= wdata;
            dq_oe_ff <= ~is_read;
            ce_n_ff  <= 1'b0;
            oe_n_ff  <= ~is_read;
            we_n_ff  <= is_read;
            cnt_ff   <= is_read ? RD_CNT : WR_CNT;
            st_ff    <= S_ACT;
          end
        end
        S_ACT: begin
          if (cnt_ff == 4'h0) begin
            // data sampled after full random access and sync delay
            if (rd_ff && (s2_ff == s3_ff)) begin
              rdata_ff <= s3_ff;
            end
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            st_ff   <= S_END;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        S_END: begin
          dq_oe_ff <= 1'b0;
          done_ff  <= 1'b1;
          st_ff    <= S_IDLE;
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: hw/fcio_host.v */
// fcio_host.v: host controller issuing flash command sequences
// assumes: AXI4-Lite master for software; flash on asynchronous pins
//
// Overview of operation
// - only reads of array, id, status data use read cycles; rest writes.
// - array read is one plain read cycle, no unlock first.
// - host issues reset command leaving id mode; timing flag only goes to status.
// - after buffer abort, host sends full unlocked abort reset sequence.
// - password words 0 to 3 in ascending order, all four covered.
// - one password word per program command, ascending from word 0.
// - every id entry sequence is closed by the reset command.
// - offset 02h shows lock state only for entry sector.
// - chip enable toggles high before each read of offset 02h.
// - no page reads between offset 02h and other id words.
`timescale 1ns/1ns
`include "fcio_consts.vh"
module fcio_host (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // flash pins
  output wire        flash_ce_n,
  output wire        flash_oe_n,
  output wire        flash_we_n,
  output wire [25:0] flash_addr,
  output wire [15:0] flash_dq_o,
  output wire        flash_dq_oe,
  input  wire [15:0] flash_dq_i
);
  localparam S_IDLE = 4'b0001;
  localparam S_ISSUE = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_FIN = 4'b1000;
  // software registers
  reg [3:0]  op_ff;
  reg [25:0] addr_ff;
  reg [15:0] wdata_ff;
  reg        busy_ff;
  reg        done_ff;
  reg        err_ff;
  reg        timex_ff;
  reg [15:0] rdata_ff;
  reg [15:0] id_ff [0:3];
  // axi write side
  reg        aw_ok_ff;
  reg        w_ok_ff;
  reg [7:0]  awaddr_ff;
  reg [31:0] wd_ff;
  // sequencer
  reg [3:0]  st_ff;
  reg [2:0]  step_ff;
  reg [2:0]  nsteps_ff;
  reg [1:0]  pwd_next_ff;
  reg        cyc_start_ff;
  reg        cyc_read;
  reg [25:0] cyc_addr;
  reg [15:0] cyc_data;
  wire       cyc_done;
  wire [15:0] cyc_rdata;
  wire [25:0] sect_base;
  wire       go_write;
  wire [2:0] id_idx;
  integer    i;
  assign sect_base = {addr_ff[25:`FCIO_SECTOR_LSB], 16'h0000};
  assign go_write = aw_ok_ff && w_ok_ff &&
                    (awaddr_ff == `FCIO_REG_CTRL) && wd_ff[`FCIO_CTRL_GO];
  assign id_idx = step_ff - 3'd3;
  fcio_bus_cycle u_cyc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (cyc_start_ff),
    .is_read  (cyc_read),
    .addr     (cyc_addr),
    .wdata    (cyc_data),
    .done_ff  (cyc_done),
    .rdata_ff (cyc_rdata),
    .ce_n_ff  (flash_ce_n),
    .oe_n_ff  (flash_oe_n),
    .we_n_ff  (flash_we_n),
    .fa_ff    (flash_addr),
    .dq_o_ff  (flash_dq_o),
    .dq_oe_ff (flash_dq_oe),
    .dq_i     (flash_dq_i)
  );
  // sequence table: step -> cycle of the chosen operation
  always @* begin
    cyc_read = 1'b0;
    cyc_addr = {10'h000, `FCIO_UNLOCK_A1};
    cyc_data = `FCIO_UNLOCK_D1;
    case (op_ff)
      `FCIO_OP_READ: begin
        cyc_read = 1'b1;
        cyc_addr = addr_ff;
      end
      `FCIO_OP_WRITE: begin
        cyc_addr = addr_ff;
        cyc_data = wdata_ff;
      end
      `FCIO_OP_RESET: begin
        cyc_data = `FCIO_CMD_RESET;
      end
      `FCIO_OP_EXIT: begin
        // two cycle exit closing an entry
        cyc_data = (step_ff == 3'd0) ? `FCIO_CMD_ID_ENTRY : `FCIO_CMD_EXIT2;
      end
      `FCIO_OP_ABORT_RST: begin
        // full unlocked abort reset
        case (step_ff)
          3'd0: cyc_data = `FCIO_UNLOCK_D1;
          3'd1: begin
            cyc_addr = {10'h000, `FCIO_UNLOCK_A2};
            cyc_data = `FCIO_UNLOCK_D2;
          end
          default: cyc_data = `FCIO_CMD_RESET;
        endcase
      end
      `FCIO_OP_PWD_PROG: begin
        // one word per program, ascending offsets
        if (step_ff == 3'd0) begin
          cyc_data = `FCIO_CMD_PROGRAM;
        end else begin
          cyc_addr = {24'h00_0000, pwd_next_ff};
          cyc_data = wdata_ff;
        end
      end
      `FCIO_OP_ID_READ: begin
        // unlock, entry at sector, four id reads, reset
        case (step_ff)
          3'd0: cyc_data = `FCIO_UNLOCK_D1;
          3'd1: begin
            cyc_addr = {10'h000, `FCIO_UNLOCK_A2};
            cyc_data = `FCIO_UNLOCK_D2;
          end
          3'd2: begin
            cyc_addr = sect_base | {10'h000, `FCIO_UNLOCK_A1};
            cyc_data = `FCIO_CMD_ID_ENTRY;
          end
          3'd3, 3'd4, 3'd5, 3'd6: begin
            // each a separate cycle with chip enable high between
            cyc_read = 1'b1;
            cyc_addr = sect_base | {24'h00_0000, id_idx[1:0]};
          end
          default: cyc_data = `FCIO_CMD_RESET; // leave id mode
        endcase
      end
      default: begin
        cyc_read = 1'b1;
        cyc_addr = addr_ff;
      end
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff        <= S_IDLE;
      step_ff      <= 3'd0;
      nsteps_ff    <= 3'd0;
      pwd_next_ff  <= 2'h0;
      cyc_start_ff <= 1'b0;
      busy_ff      <= 1'b0;
      done_ff      <= 1'b0;
      err_ff       <= 1'b0;
      timex_ff     <= 1'b0;
      rdata_ff     <= 16'h0000;
      op_ff        <= 4'h0;
      addr_ff      <= 26'h000_0000;
      wdata_ff     <= 16'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        id_ff[i] <= 16'h0000;
      end
    end else begin
      cyc_start_ff <= 1'b0;
      if (aw_ok_ff && w_ok_ff && !busy_ff) begin
        if (awaddr_ff == `FCIO_REG_ADDR) begin
          addr_ff <= wd_ff[25:0];
        end
        if (awaddr_ff == `FCIO_REG_WDATA) begin
          wdata_ff <= wd_ff[15:0];
        end
        if (awaddr_ff == `FCIO_REG_CTRL) begin
          op_ff <= wd_ff[`FCIO_CTRL_OP_MSB:`FCIO_CTRL_OP_LSB];
        end
      end
      case (st_ff)
        S_IDLE: begin
          if (go_write && !busy_ff) begin
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
            err_ff  <= 1'b0;
            step_ff <= 3'd0;
            case (wd_ff[`FCIO_CTRL_OP_MSB:`FCIO_CTRL_OP_LSB])
              `FCIO_OP_ID_READ:   nsteps_ff <= 3'd7;
              `FCIO_OP_ABORT_RST: nsteps_ff <= 3'd2;
              `FCIO_OP_EXIT:      nsteps_ff <= 3'd1;
              `FCIO_OP_PWD_PROG:  nsteps_ff <= 3'd1;
              default:            nsteps_ff <= 3'd0;
            endcase
            st_ff <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          cyc_start_ff <= 1'b1;
          st_ff        <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (cyc_read) begin
              rdata_ff <= cyc_rdata;
              // exceeded timing flag taken from data bit 5 of every read cycle
              timex_ff <= cyc_rdata[`FCIO_EXCEED_BIT];
              if (op_ff == `FCIO_OP_ID_READ) begin
                id_ff[id_idx[1:0]] <= cyc_rdata;
              end
            end
            if (step_ff == nsteps_ff) begin
              st_ff <= S_FIN;
            end else begin
              step_ff <= step_ff + 3'd1;
              st_ff   <= S_ISSUE;
            end
          end
        end
        S_FIN: begin
          if (op_ff == `FCIO_OP_PWD_PROG) begin
            pwd_next_ff <= pwd_next_ff + 2'h1;
          end
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          st_ff   <= S_IDLE;
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
      if (go_write && busy_ff) begin
        err_ff <= 1'b1;
      end
    end
  end
  // axi4-lite slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
      aw_ok_ff      <= 1'b0;
      w_ok_ff       <= 1'b0;
      awaddr_ff     <= 8'h00;
      wd_ff         <= 32'h0000_0000;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_awvalid && !aw_ok_ff && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_ok_ff      <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ok_ff && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_ok_ff      <= 1'b1;
        wd_ff        <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end
      if (aw_ok_ff && w_ok_ff) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff == `FCIO_REG_CTRL ||
                         awaddr_ff == `FCIO_REG_ADDR ||
                         awaddr_ff == `FCIO_REG_WDATA) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        case (s_axi_araddr)
          `FCIO_REG_CTRL:   s_axi_rdata <= {24'h00_0000, op_ff, 4'h0};
          `FCIO_REG_ADDR:   s_axi_rdata <= {6'h00, addr_ff};
          `FCIO_REG_WDATA:  s_axi_rdata <= {16'h0000, wdata_ff};
          `FCIO_REG_STATUS: s_axi_rdata <= {28'h000_0000, timex_ff,
                                            err_ff, done_ff, busy_ff};
          `FCIO_REG_RDATA:  s_axi_rdata <= {16'h0000, rdata_ff};
          `FCIO_REG_ID0:    s_axi_rdata <= {16'h0000, id_ff[0]};
          `FCIO_REG_ID1:    s_axi_rdata <= {16'h0000, id_ff[1]};
          `FCIO_REG_ID2:    s_axi_rdata <= {16'h0000, id_ff[2]};
          `FCIO_REG_ID3:    s_axi_rdata <= {16'h0000, id_ff[3]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: test/fcio_host_assertions.sv */
// fcio_host_assertions.sv: checks on the host's flash and axi ports
// assumes: bound to fcio_host; one clock, sync active-low reset
`timescale 1ns/1ns
module fcio_host_chk (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // axi answers
  input wire        s_axi_bvalid,
  input wire        s_axi_rvalid,
  // flash pins
  input wire        flash_ce_n,
  input wire        flash_oe_n,
  input wire        flash_we_n,
  input wire [25:0] flash_addr,
  input wire [15:0] flash_dq_o,
  input wire        flash_dq_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_one_strobe: assert property (
    flash_we_n || flash_oe_n)
    else $error("read and write strobes low together");
  chk_write_drives: assert property (
    !flash_we_n |-> flash_dq_oe && !flash_ce_n)
    else $error("write strobe without driven data");
  chk_read_floats: assert property (
    !flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("read strobe while host drives data");
  chk_write_held: assert property (
    !flash_we_n && !$past(flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in a write");
  chk_write_width: assert property (
    $fell(flash_we_n) |-> !flash_we_n [*3])
    else $error("write strobe too short");
  chk_access_time: assert property (
    $fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n) [*4])
    else $error("read cycle shorter than access time");
  chk_ce_gap: assert property (
    $rose(flash_ce_n) |-> flash_ce_n [*2])
    else $error("chip enable gap too short");
  chk_no_page: assert property (
    $rose(flash_oe_n) |-> ##[0:1] flash_ce_n)
    else $error("chip enable held across reads");
  cover property ($fell(flash_we_n));
  cover property ($fell(flash_oe_n));
  cover property (s_axi_bvalid);
  cover property (s_axi_rvalid);
endmodule

/* File: test/fcio_flash_model.sv */
// fcio_flash_model.sv: behavioural flash device on the host's pins
// assumes: split data bus, low-active strobes, words at word addresses
`timescale 1ns/1ns
module fcio_flash_model #(
  parameter [15:0] MAKER    = 16'h5a3c, // arbitrary value
  parameter [15:0] PART     = 16'h6e1d, // arbitrary value
  parameter [15:0] FEATURE  = 16'hffbf,
  parameter [9:0]  PROT_SEC = 10'h005,
  parameter        RANDOM_ACCESS_TIME_NS  = 100
) (
  // strobes
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  // address and data
  input  wire [25:0] addr,
  input  wire [15:0] dq_o,
  input  wire        dq_oe,
  output wire [15:0] dq_i
);
  reg  [15:0] dq_r = 16'h0000;
  reg  [15:0] wd = 16'h0000;
  reg  [25:0] wa = 26'h0;
  reg  [15:0] pwd_mem [0:3];
  reg  [9:0]  sector = 10'h000;
  reg  [1:0]  step = 2'h0;
  reg  [1:0]  pwd_next = 2'h0;
  reg         id_mode = 1'b0;
  reg         ex_wait = 1'b0;
  reg         pgm = 1'b0;
  reg         fresh = 1'b0;
  reg         pwd_bad = 1'b0;
  reg         lock_mode = 1'b0;
  wire [7:0]  wcmd = wd[7:0];
  wire [10:0] wlow = wa[10:0];
  assign dq_i = dq_oe ? dq_o : dq_r;
  function [15:0] rd_word(input [25:0] ra);
    begin
      if (lock_mode)
        rd_word = {15'h0000, ra[25:16] != PROT_SEC};
      else if (!id_mode)
        rd_word = ra[15:0] ^ 16'ha5a5;
      else if (ra[1:0] == 2'h0)
        rd_word = MAKER;
      else if (ra[1:0] == 2'h1)
        rd_word = PART;
      else if (ra[1:0] == 2'h3)
        rd_word = FEATURE;
      else if (ra[25:16] == sector && fresh)
        rd_word = {15'h0000, sector == PROT_SEC};
      else
        rd_word = ~dq_r;
    end
  endfunction
  // read cycles: garbage until access time, inverse once released
  always @(negedge ce_n) fresh = 1'b1;
  always @(negedge oe_n) begin
    #1 dq_r = ~dq_r;
    #(RANDOM_ACCESS_TIME_NS - 1) if (!oe_n && !ce_n) dq_r = rd_word(addr);
    fresh = 1'b0;
  end
  always @(posedge oe_n) dq_r = ~dq_r;
  // write cycles: latched after the fall, decoded at the rise
  always @(negedge we_n) begin
    #1 wa = addr;
    wd = dq_o;
  end
  always @(posedge we_n) begin
    if (pgm) begin
      pgm = 1'b0;
      pwd_bad = pwd_bad | (wa[1:0] != pwd_next);
      pwd_mem[wa[1:0]] = wd;
      pwd_next = pwd_next + 2'h1;
    end else if (ex_wait) begin
      ex_wait = 1'b0;
      if (wcmd == 8'h00) {id_mode, lock_mode} = 2'b00;
    end else if (step == 2'h0) begin
      step = (wlow == 11'h555 && wcmd == 8'haa) ? 2'h1 : 2'h0;
      if (wcmd == 8'hf0) {id_mode, lock_mode} = 2'b00;
      ex_wait = (wcmd == 8'h90);
      pgm = (wcmd == 8'ha0);
    end else if (step == 2'h1) begin
      step = (wlow == 11'h2aa && wcmd == 8'h55) ? 2'h2 : 2'h0;
    end else begin
      step = 2'h0;
      if (wcmd == 8'hf0) {id_mode, lock_mode} = 2'b00;
      if (wlow == 11'h555 && wcmd == 8'he0) lock_mode = 1'b1;
      if (wlow == 11'h555 && wcmd == 8'h90) begin
        id_mode = 1'b1;
        sector = wa[25:16];
      end
    end
  end
endmodule

/* File: test/test_flash_command_id_overlay.sv */
// test_flash_command_id_overlay.sv: self-checking bench for fcio_host
// assumes: flash model on the pins, checker bound below
`timescale 1ns/1ns
`include "fcio_consts.vh"
module test_flash_command_id_overlay;
  localparam [15:0] MAKER = 16'h5a3c; // arbitrary value
  localparam [15:0] PART  = 16'h6e1d; // arbitrary value
  localparam [15:0] FEAT  = 16'hffbf;
  localparam [9:0]  PSEC  = 10'h005;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg         awvalid, wvalid, bready, arvalid, rready;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        ce_n, oe_n, we_n, dq_oe;
  wire [25:0] fa;
  wire [15:0] dq_o, dq_i;
  integer     fails, check_count, seed, i, j;
  reg  [31:0] rd, st;
  reg  [1:0]  rsp;
  reg  [25:0] a;
  reg  [15:0] idw [0:3];
  reg  [15:0] pw [0:3];
  reg  [3:0]  xop [0:2];
  fcio_host fcio_host_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  fcio_flash_model #(.MAKER(MAKER), .PART(PART), .FEATURE(FEAT),
    .PROT_SEC(PSEC)) fcio_flash_model_i (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(fa), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  task cmp(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("mismatch %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task axi(input w, input [7:0] ad, input [31:0] d);
    reg fin;
    begin
      @(posedge aclk);
      awaddr <= ad;
      araddr <= ad;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      fin = 1'b0;
      while (!fin) begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (arready === 1'b1) arvalid <= 1'b0;
        fin = ((w ? bvalid : rvalid) === 1'b1);
      end
      rsp = w ? bresp : rresp;
      rd = rdata;
      bready <= 1'b0;
      rready <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] ad, input [31:0] e);
    begin
      axi(1'b0, ad, 32'h0000_0000);
      cmp(rd, e);
    end
  endtask
  task wait_done;
    integer n;
    begin
      n = 0;
      st = 32'h0000_0000;
      while (st[1] !== 1'b1 && n < 300) begin
        axi(1'b0, `FCIO_REG_STATUS, 32'h0000_0000);
        st = rd;
        n = n + 1;
      end
    end
  endtask
  task run_op(input [3:0] op, input [25:0] ad, input [15:0] d);
    begin
      axi(1'b1, `FCIO_REG_ADDR, {6'h00, ad});
      axi(1'b1, `FCIO_REG_WDATA, {16'h0000, d});
      axi(1'b1, `FCIO_REG_CTRL, {24'h00_0000, op, 4'h1});
      wait_done;
      cmp(st & 32'h0000_0007, 32'h0000_0002);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #2000000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    fails = 0;
    check_count = 0;
    seed = 32'hc87d;
    xop[0] = `FCIO_OP_EXIT;
    xop[1] = `FCIO_OP_RESET;
    xop[2] = `FCIO_OP_ABORT_RST;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`FCIO_REG_STATUS, 32'h0000_0000);
    axi(1'b0, 8'h40, 32'h0000_0000);
    cmp({30'h0, rsp}, 32'h0000_0002);
    axi(1'b1, 8'h44, 32'h0000_0000);
    cmp({30'h0, rsp}, 32'h0000_0002);
    for (i = 0; i < 6; i = i + 1) begin
      rd = $random(seed);
      a = rd[25:0];
      run_op(`FCIO_OP_READ, a, 16'h0000);
      rd = {16'h0000, a[15:0] ^ 16'ha5a5};
      rd_chk(`FCIO_REG_RDATA, rd);
      rd_chk(`FCIO_REG_STATUS, {28'h0, ~a[5], 3'b010});
    end
    // identification words for a protected and an open sector
    for (i = 0; i < 2; i = i + 1) begin
      a = {PSEC + i[9:0], 16'h0000};
      idw[0] = MAKER;
      idw[1] = PART;
      idw[2] = (i == 0) ? 16'h0001 : 16'h0000;
      idw[3] = FEAT;
      run_op(`FCIO_OP_ID_READ, a, 16'h0000);
      for (j = 0; j < 4; j = j + 1)
        rd_chk(8'h14 + j * 4, {16'h0000, idw[j]});
      run_op(`FCIO_OP_READ, a, 16'h0000);
      rd_chk(`FCIO_REG_RDATA, {16'h0000, 16'ha5a5});
    end
    // enter overlay by hand, leave it each documented way
    for (i = 0; i < 3; i = i + 1) begin
      run_op(`FCIO_OP_WRITE, {10'h000, `FCIO_UNLOCK_A1}, `FCIO_UNLOCK_D1);
      run_op(`FCIO_OP_WRITE, {10'h000, `FCIO_UNLOCK_A2}, `FCIO_UNLOCK_D2);
      run_op(`FCIO_OP_WRITE, {PSEC, `FCIO_UNLOCK_A1}, `FCIO_CMD_ID_ENTRY);
      run_op(`FCIO_OP_READ, {PSEC, 16'h0001}, 16'h0000);
      rd_chk(`FCIO_REG_RDATA, {16'h0000, PART});
      run_op(xop[i], 26'h0, 16'h0000);
      run_op(`FCIO_OP_READ, {PSEC, 16'h0001}, 16'h0000);
      rd_chk(`FCIO_REG_RDATA, {16'h0000, 16'ha5a4});
    end
    // volatile lock status of a protected and an open sector
    for (i = 0; i < 2; i = i + 1) begin
      run_op(`FCIO_OP_WRITE, {10'h000, `FCIO_UNLOCK_A1}, `FCIO_UNLOCK_D1);
      run_op(`FCIO_OP_WRITE, {10'h000, `FCIO_UNLOCK_A2}, `FCIO_UNLOCK_D2);
      run_op(`FCIO_OP_WRITE, {10'h000, `FCIO_UNLOCK_A1}, 16'h00E0);
      run_op(`FCIO_OP_READ, {PSEC + i[9:0], 16'h0000}, 16'h0000);
      rd_chk(`FCIO_REG_RDATA, i);
      run_op(`FCIO_OP_RESET, 26'h0, 16'h0000);
    end
    for (j = 0; j < 4; j = j + 1) begin
      rd = $random(seed);
      pw[j] = rd[15:0];
      run_op(`FCIO_OP_PWD_PROG, 26'h0, pw[j]);
    end
    for (j = 0; j < 4; j = j + 1)
      cmp({16'h0, fcio_flash_model_i.pwd_mem[j]}, {16'h0, pw[j]});
    cmp({31'h0, fcio_flash_model_i.pwd_bad}, 32'h0000_0000);
    // a second start while busy is refused with an error
    axi(1'b1, `FCIO_REG_CTRL, {24'h00_0000, `FCIO_OP_ID_READ, 4'h1});
    axi(1'b1, `FCIO_REG_CTRL, {24'h00_0000, `FCIO_OP_ID_READ, 4'h1});
    wait_done;
    cmp(st & 32'h0000_0006, 32'h0000_0006);
    run_op(`FCIO_OP_RESET, 26'h0, 16'h0000);
    print_verdict;
  end
endmodule
bind fcio_host fcio_host_chk fcio_host_chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe));
